// File: scr_defines.svh
// Timing counts, pin positions and reset values of the config readout.
`ifndef SCR_DEFINES_SVH
`define SCR_DEFINES_SVH

// Power-on reset length in clk_sys cycles.
`define SCR_POR_W 8
`define SCR_POR_CYCLES 8'h10

// Internal oscillator half period in clk_sys cycles (10 MHz at 40 MHz).
`define SCR_OSC_W 4
`define SCR_OSC_HALF 4'h2

// Polarity bytes, loaded with this value by rst_n; all at this value means reset active low.
`define SCR_POL_BYTES 4
`define SCR_POL_SEL_W 2
`define SCR_POL_BYTE_W 8
`define SCR_POL_RST_LOW 8'hFF

// Default memory density in bits and size of a protected block.
`define SCR_MEM_BITS 65536
`define SCR_BLOCK_SHIFT 2

// Positions of the pins in the synchroniser vector.
`define SCR_SYNC_W 8
`define SCR_SYNC_RST 8'h0C
`define SCR_IN_CLK 0
`define SCR_IN_ROE 1
`define SCR_IN_CS 2
`define SCR_IN_PME 3
`define SCR_IN_PWP 4
`define SCR_IN_BWP 5
`define SCR_IN_DSEL 6
`define SCR_IN_DATA 7

`endif

// File: scr_pkg.sv
// Shared types of the serial configuration memory readout.
`default_nettype none

package scr_pkg;

  typedef enum logic [1:0] {
    ST_POR,
    ST_RUN,
    ST_DONE,
    ST_PROG
  } scr_state_t;

  typedef enum logic {
    ROLE_MASTER,
    ROLE_SUBSEQ
  } scr_role_t;

endpackage

`default_nettype wire

// File: scr_osc_if.sv
// Control and clock lines between the readout and its oscillator.
`timescale 1ns/1ps
`default_nettype none

interface scr_osc_if;
  logic run;
  logic level;
  logic rise;
  modport ctrl (output run, input level, input rise);
  modport osc (input run, output level, output rise);
endinterface

`default_nettype wire

// File: scr_sync.sv
// Two flip-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
`default_nettype none

module scr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)(
  // System
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins and their synchronised copies
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // scr_sync

`default_nettype wire

// File: scr_osc.sv
// Internal oscillator that drives the link clock of a master device.
`timescale 1ns/1ps
`default_nettype none
`include "scr_defines.svh"

module scr_osc #(
  parameter logic [`SCR_OSC_W-1:0] HALF = `SCR_OSC_HALF
)(
  // System
  input wire logic clk_sys,
  input wire logic rst_n,
  // Oscillator lines
  scr_osc_if.osc bus
);

  logic [`SCR_OSC_W-1:0] div_q;
  logic level_q;
  logic rise_q;
  logic tick;

  assign tick = (div_q == HALF - `SCR_OSC_W'(1));
  assign bus.level = level_q;
  assign bus.rise = rise_q;

  // The clock stops low whenever run falls.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || !bus.run)
    begin
      div_q <= '0;
      level_q <= 1'b0;
    end
    else if (tick)
    begin
      div_q <= '0;
      level_q <= ~level_q;
    end
    else
    begin
      div_q <= div_q + `SCR_OSC_W'(1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rise_q <= 1'b0;
    end
    else
    begin
      rise_q <= bus.run & tick & ~level_q;
    end
  end

endmodule // scr_osc

`default_nettype wire

// File: scr_top.sv
// Serial readout of a configuration memory with cascade and programming.
//
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "scr_defines.svh"

module scr_top
  import scr_pkg::*;
#(
  parameter int MEM_BITS = `SCR_MEM_BITS,
  parameter bit USE_INT_OSC = 1'b1
)(
  // System
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link clock pin
  input wire logic config_clock_i,
  output logic config_clock_o,
  output logic config_clock_oe,
  // Serial data pin
  input wire logic data_i,
  output logic data_o,
  output logic data_oe,
  // Control pins
  input wire logic reset_output_enable,
  input wire logic chip_select_n,
  input wire logic program_mode_enable_n,
  input wire logic partial_write_protect,
  input wire logic block_write_protect,
  input wire logic device_select_pin,
  // Cascade and status pins
  output logic chain_next_select_n,
  output logic ready_o,
  output logic ready_oe,
  output logic standby,
  // Programming engine
  input wire logic prog_wr_en,
  input wire logic [$clog2(MEM_BITS)-1:0] prog_addr,
  input wire logic prog_wdata,
  input wire logic prog_sda_low,
  output logic prog_sda_in,
  output logic prog_mode,
  input wire logic pol_wr_en,
  input wire logic [`SCR_POL_SEL_W-1:0] pol_sel,
  input wire logic [`SCR_POL_BYTE_W-1:0] pol_wdata
);

  localparam int AW = $clog2(MEM_BITS);
  localparam int BLOCK_BITS = MEM_BITS >> `SCR_BLOCK_SHIFT;
  localparam logic [AW-1:0] LAST_ADDR = AW'(MEM_BITS - 1);
  localparam logic [AW-1:0] LOW_TOP = AW'(BLOCK_BITS);
  localparam logic [AW-1:0] HIGH_BASE = AW'(MEM_BITS - BLOCK_BITS);

  //--------------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------------

  logic [`SCR_SYNC_W-1:0] pins_raw;
  logic [`SCR_SYNC_W-1:0] pins_s;
  logic clk_s;
  logic roe_s;
  logic cs_s;
  logic pwp_s;
  logic bwp_s;
  logic dsel_s;

  assign pins_raw = {data_i, device_select_pin, block_write_protect,
                     partial_write_protect, program_mode_enable_n,
                     chip_select_n, reset_output_enable, config_clock_i};

  scr_sync #(
    .W(`SCR_SYNC_W),
    .RST_VAL(`SCR_SYNC_RST)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(pins_raw),
    .q(pins_s)
  );

  assign clk_s = pins_s[`SCR_IN_CLK];
  assign roe_s = pins_s[`SCR_IN_ROE];
  assign cs_s = pins_s[`SCR_IN_CS];
  assign pwp_s = pins_s[`SCR_IN_PWP];
  assign bwp_s = pins_s[`SCR_IN_BWP];
  assign dsel_s = pins_s[`SCR_IN_DSEL];
  assign prog_sda_in = pins_s[`SCR_IN_DATA];
  assign prog_mode = ~pins_s[`SCR_IN_PME];

  //--------------------------------------------------------------------
  // Reset polarity bytes
  //--------------------------------------------------------------------

  logic [`SCR_POL_BYTE_W-1:0] pol_q [`SCR_POL_BYTES];
  logic pol_rst_low;
  logic rst_active;
  logic prog_sel;

  // Device select only qualifies programming access; chip select also gates the readout.
  assign prog_sel = prog_mode & ~cs_s & dsel_s;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `SCR_POL_BYTES; i++)
      begin
        pol_q[i] <= `SCR_POL_RST_LOW;
      end
    end
    else if (prog_sel && pol_wr_en)
    begin
      pol_q[pol_sel] <= pol_wdata;
    end
  end

  always_comb
  begin
    pol_rst_low = 1'b1;
    for (int i = 0; i < `SCR_POL_BYTES; i++)
    begin
      if (pol_q[i] != `SCR_POL_RST_LOW)
      begin
        pol_rst_low = 1'b0;
      end
    end
  end

  // The pin only acts as reset outside programming mode.
  assign rst_active = ~prog_mode & (pol_rst_low ? ~roe_s : roe_s);

  //--------------------------------------------------------------------
  // Sequence state
  //--------------------------------------------------------------------

  scr_state_t state_q;
  scr_state_t state_d;
  scr_role_t role_q;
  logic [`SCR_POR_W-1:0] por_q;
  logic por_done;
  logic clk_prev_q;
  logic ext_rise;
  logic int_clk;
  logic rise;
  logic cnt_en;
  logic adv;
  logic last_rise;
  logic [AW-1:0] addr_q;
  scr_osc_if osc_bus ();

  assign por_done = (por_q == `SCR_POR_CYCLES);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      por_q <= '0;
    end
    else if (state_q == ST_POR && !por_done)
    begin
      por_q <= por_q + `SCR_POR_W'(1);
    end
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_POR:
        if (por_done) state_d = ST_RUN;
      ST_RUN:
        if (prog_mode) state_d = ST_PROG;
        else if (last_rise) state_d = ST_DONE;
      ST_DONE:
        if (prog_mode) state_d = ST_PROG;
        else if (rst_active) state_d = ST_RUN;
      ST_PROG:
        if (!prog_mode) state_d = ST_RUN;
      default:
        state_d = ST_POR;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_q <= ST_POR;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // The select level seen while in reset fixes the role in the chain.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      role_q <= ROLE_MASTER;
    end
    else if (state_q == ST_POR || rst_active)
    begin
      role_q <= cs_s ? ROLE_SUBSEQ : ROLE_MASTER;
    end
  end

  //--------------------------------------------------------------------
  // Link clock and address counter
  //--------------------------------------------------------------------

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      clk_prev_q <= 1'b0;
    end
    else
    begin
      clk_prev_q <= clk_s;
    end
  end

  assign ext_rise = clk_s & ~clk_prev_q;
  assign int_clk = USE_INT_OSC && (role_q == ROLE_MASTER);
  // A subsequent device counts on the clock that the master makes.
  assign rise = int_clk ? osc_bus.rise : ext_rise;
  assign cnt_en = (state_q == ST_RUN) & ~rst_active & ~cs_s
                  & ~prog_mode;
  assign adv = cnt_en & rise;
  assign last_rise = adv & (addr_q == LAST_ADDR);

  // The oscillator runs only while counting; otherwise the pin sits low, and in programming mode it is released.
  assign osc_bus.run = int_clk & cnt_en;
  assign config_clock_o = osc_bus.level;
  assign config_clock_oe = int_clk & ~prog_mode;

  scr_osc u_osc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus(osc_bus)
  );

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || state_q == ST_POR)
    begin
      addr_q <= '0;
    end
    else if (rst_active)
    begin
      addr_q <= '0;
    end
    else if (adv && !last_rise)
    begin
      addr_q <= addr_q + AW'(1);
    end
  end

  //--------------------------------------------------------------------
  // Memory array and programming writes
  //--------------------------------------------------------------------

  logic mem_q [MEM_BITS];
  logic wr_block_low;
  logic wr_block_high;
  logic wr_fire;

  assign wr_block_low = bwp_s & (prog_addr < LOW_TOP);
  assign wr_block_high = pwp_s & (prog_addr >= HIGH_BASE);
  assign wr_fire = (state_q == ST_PROG) & prog_sel & prog_wr_en
                   & ~wr_block_low & ~wr_block_high;

  always_ff @(posedge clk_sys)
  begin
    if (wr_fire)
    begin
      mem_q[prog_addr] <= prog_wdata;
    end
  end

  //--------------------------------------------------------------------
  // Data, cascade and status outputs
  //--------------------------------------------------------------------

  logic data_q;
  logic data_oe_q;
  logic casc_n_q;
  logic ready_oe_q;
  logic standby_q;
  logic read_oe_d;

  assign read_oe_d = cnt_en & ~last_rise;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      data_q <= 1'b0;
      data_oe_q <= 1'b0;
    end
    else if (prog_mode)
    begin
      data_q <= 1'b0;
      data_oe_q <= prog_sel & prog_sda_low;
    end
    else
    begin
      data_q <= mem_q[addr_q];
      data_oe_q <= read_oe_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      casc_n_q <= 1'b1;
    end
    else
    begin
      casc_n_q <= (state_d != ST_DONE);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ready_oe_q <= 1'b1;
      standby_q <= 1'b0;
    end
    else
    begin
      ready_oe_q <= (state_d == ST_POR);
      standby_q <= cs_s;
    end
  end

  assign data_o = data_q;
  assign data_oe = data_oe_q;
  assign chain_next_select_n = casc_n_q;
  assign ready_o = 1'b0;
  assign ready_oe = ready_oe_q;
  assign standby = standby_q;

  //--------------------------------------------------------------------
  // Assertions
  //--------------------------------------------------------------------

  logic [AW-1:0] wr_addr_old_q;
  logic wr_bit_old_q;

  always_ff @(posedge clk_sys)
  begin
    wr_addr_old_q <= prog_addr;
    wr_bit_old_q <= mem_q[prog_addr];
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  property p_rst_clear;
    rst_active |=> (addr_q == '0) && !data_oe;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("reset level did not clear counter and data driver");

  property p_cs_off;
    cs_s && !prog_mode |=> !data_oe && standby;
  endproperty
  a_cs_off: assert property (p_cs_off)
    else $error("data driven while chip select is high");

  property p_por_addr;
    state_q == ST_POR |-> addr_q == '0 && ready_oe && !ready_o;
  endproperty
  a_por_addr: assert property (p_por_addr)
    else $error("power-on state without cleared counter or ready low");

  property p_advance;
    adv && !last_rise |=> addr_q == $past(addr_q) + AW'(1);
  endproperty
  a_advance: assert property (p_advance)
    else $error("address did not advance on clock rise");

  property p_hold;
    !adv && !rst_active && state_q == ST_RUN |=> $stable(addr_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("address moved without enable and clock rise");

  property p_osc_low;
    rst_active && int_clk |=> !config_clock_o [*2];
  endproperty
  a_osc_low: assert property (p_osc_low)
    else $error("link clock not held low during reset");

  property p_cascade;
    last_rise |=> !chain_next_select_n && !data_oe;
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("cascade select or data float missing after last bit");

  property p_role;
    rst_active |=> role_q == ($past(cs_s) ? ROLE_SUBSEQ : ROLE_MASTER);
  endproperty
  a_role: assert property (p_role)
    else $error("chain role does not follow select level at reset");

  property p_block_low;
    state_q == ST_PROG && prog_wr_en && bwp_s && prog_addr < LOW_TOP
      |=> mem_q[wr_addr_old_q] == wr_bit_old_q;
  endproperty
  a_block_low: assert property (p_block_low)
    else $error("write reached the protected lowest block");

  property p_dsel;
    !dsel_s |-> !wr_fire;
  endproperty
  a_dsel: assert property (p_dsel)
    else $error("write accepted while device is not selected");

endmodule // scr_top

`default_nettype wire

// File: scr_host_model.sv
// Link-side model: external clock source and the configuring target's input.
`timescale 1ns/1ps
`default_nettype none

module scr_host_model (
  // Control from the bench
  input wire logic start,
  input wire logic [4:0] n_rise,
  // Link pins
  input wire logic data_pin,
  output logic config_clock,
  // Captured stream, first bit ends lowest
  output logic [15:0] got,
  output logic busy
);
  // The clock stands low between frames and its phase is unrelated to clk_sys.
  initial
  begin
    config_clock = 1'h0;
    got = 16'h0000;
    busy = 1'h0;
    forever
    begin
      wait (start);
      #7;
      busy = 1'h1;
      for (int i = 0; i < n_rise; i++)
      begin
        #100;
        got = {data_pin, got[15:1]};
        config_clock = 1'h1;
        #100;
        config_clock = 1'h0;
      end
      busy = 1'h0;
      wait (!start);
    end
  end
endmodule // scr_host_model

`default_nettype wire

// File: test_scr_top.sv
// Self-checking bench of the configuration readout.
`timescale 1ns/1ps
`default_nettype none

module test_scr_top;
  localparam logic [15:0] PAT = 16'hC5A3;
  logic clk_sys, rst_n, start, pull_low, busy;
  logic [4:0] n_rise;
  logic [15:0] got;
  logic config_clock_i, config_clock_o, config_clock_oe, data_o, data_oe;
  logic reset_output_enable, chip_select_n, program_mode_enable_n;
  logic partial_write_protect, block_write_protect, device_select_pin;
  logic chain_next_select_n, ready_o, ready_oe, standby;
  logic prog_wr_en, prog_wdata, prog_sda_low, prog_sda_in, prog_mode;
  logic pol_wr_en;
  logic [3:0] prog_addr;
  logic [1:0] pol_sel;
  logic [7:0] pol_wdata;
  int n_mismatch, tests_run;
  // The data line has a pull-up; the bench may pull it low in programming.
  wire logic data_pin = (data_oe ? data_o : 1'h1) & ~pull_low;

  scr_top #(.MEM_BITS(16), .USE_INT_OSC(1'b0)) scr_top_inst (
    .clk_sys, .rst_n, .config_clock_i, .config_clock_o, .config_clock_oe,
    .data_i(data_pin), .data_o, .data_oe, .reset_output_enable,
    .chip_select_n, .program_mode_enable_n, .partial_write_protect,
    .block_write_protect, .device_select_pin, .chain_next_select_n,
    .ready_o, .ready_oe, .standby, .prog_wr_en, .prog_addr, .prog_wdata,
    .prog_sda_low, .prog_sda_in, .prog_mode, .pol_wr_en, .pol_sel,
    .pol_wdata
  );

  scr_host_model scr_host_model_inst (
    .start, .n_rise, .data_pin, .config_clock(config_clock_i), .got, .busy
  );

  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Compares at once; callers first settle on a falling edge.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Waits n rising edges, then the falling edge where registers have settled.
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic write_bit(input logic [3:0] a, input logic d);
    @(posedge clk_sys);
    prog_wr_en <= 1'h1;
    prog_addr <= a;
    prog_wdata <= d;
    @(posedge clk_sys);
    prog_wr_en <= 1'h0;
  endtask

  // Runs n link clock rises and waits for the frame to end.
  task automatic stream(input logic [4:0] n);
    @(posedge clk_sys);
    n_rise <= n;
    start <= 1'h1;
    for (int k = 0; k < 400 && busy !== 1'h1; k++)
      @(posedge clk_sys);
    if (busy !== 1'h1)
    begin
      n_mismatch++;
      complete_run();
    end
    start <= 1'h0;
    for (int k = 0; k < 2000 && busy !== 1'h0; k++)
      @(posedge clk_sys);
    if (busy !== 1'h0)
    begin
      n_mismatch++;
      complete_run();
    end
    settle(6);
  endtask

  initial
  begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    complete_run();
  end

  initial
  begin
    {rst_n, start, pull_low, n_rise, prog_wr_en, prog_wdata} = '0;
    {prog_sda_low, pol_wr_en, prog_addr, pol_sel, pol_wdata} = '0;
    {partial_write_protect, block_write_protect, device_select_pin} = '0;
    {reset_output_enable, chip_select_n, program_mode_enable_n} = 3'h5;
    n_mismatch = 0;
    tests_run = 0;
    tick(8);
    rst_n <= 1'h1;
    settle(8);
    check(16'({ready_oe, ready_o}), 16'h0002);
    settle(14);
    check(16'({ready_oe, ready_o}), 16'h0000);
    // Programming: polarity bytes, pattern, then refused writes.
    tick(1);
    program_mode_enable_n <= 1'h0;
    device_select_pin <= 1'h1;
    settle(4);
    check(16'(prog_mode), 16'h0001);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      pol_wr_en <= 1'h1;
      pol_sel <= 2'(i);
      pol_wdata <= 8'hFF;
      @(posedge clk_sys);
      pol_wr_en <= 1'h0;
    end
    for (int i = 0; i < 16; i++)
      write_bit(4'(i), PAT[i]);
    block_write_protect <= 1'h1;
    partial_write_protect <= 1'h1;
    tick(4);
    write_bit(4'h0, ~PAT[0]);
    write_bit(4'hF, ~PAT[15]);
    prog_sda_low <= 1'h1;
    pull_low <= 1'h1;
    settle(4);
    check(16'({data_oe, data_o, prog_sda_in}), 16'h0004);
    tick(1);
    prog_sda_low <= 1'h0;
    pull_low <= 1'h0;
    device_select_pin <= 1'h0;
    tick(4);
    write_bit(4'h5, ~PAT[5]);
    // Readout as a subsequent device: idle until selected.
    program_mode_enable_n <= 1'h1;
    chip_select_n <= 1'h1;
    tick(4);
    rst_n <= 1'h0;
    tick(2);
    rst_n <= 1'h1;
    settle(24);
    check(16'({standby, data_oe}), 16'h0002);
    check(16'(config_clock_oe), 16'h0000);
    stream(5'h04);
    tick(1);
    chip_select_n <= 1'h0;
    settle(4);
    check(16'(data_oe), 16'h0001);
    stream(5'h10);
    check(got, PAT);
    check(16'({chain_next_select_n, data_oe}), 16'h0000);
    stream(5'h02);
    check(16'({chain_next_select_n, data_oe}), 16'h0000);
    // Reset pin low after loading restarts the stream.
    tick(1);
    reset_output_enable <= 1'h0;
    settle(4);
    check(16'({chain_next_select_n, data_oe}), 16'h0002);
    check(16'(config_clock_o), 16'h0000);
    tick(1);
    reset_output_enable <= 1'h1;
    tick(4);
    stream(5'h04);
    check(16'(got[15:12]), 16'(PAT[3:0]));
    // Power-on reset in mid-stream returns to the first bit.
    tick(1);
    rst_n <= 1'h0;
    tick(2);
    rst_n <= 1'h1;
    tick(24);
    stream(5'h04);
    check(16'(got[15:12]), 16'(PAT[3:0]));
    // Any polarity byte off its reset value makes reset active high.
    tick(1);
    program_mode_enable_n <= 1'h0;
    device_select_pin <= 1'h1;
    tick(4);
    pol_wr_en <= 1'h1;
    pol_sel <= 2'h0;
    pol_wdata <= 8'h00;
    tick(1);
    pol_wr_en <= 1'h0;
    program_mode_enable_n <= 1'h1;
    settle(6);
    check(16'(data_oe), 16'h0000);
    tick(1);
    reset_output_enable <= 1'h0;
    settle(4);
    check(16'(data_oe), 16'h0001);
    tick(1);
    chip_select_n <= 1'h1;
    settle(4);
    check(16'({standby, data_oe}), 16'h0002);
    complete_run();
  end
endmodule // test_scr_top

`default_nettype wire
